/* adc_sync_regs.vh */
`ifndef ADC_SYNC_REGS_VH
`define ADC_SYNC_REGS_VH

// ----------------------------------------------------------------------
// Bus addresses and data layout
// ----------------------------------------------------------------------
`define GLOBAL_ADDR 7'h77
`define RESULT_BITS 24
`define RESULT_BYTES 2'h3
`define CHAN_DEFAULT 8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ 25000000
`define SAMP_FREQ_HZ 123000
`define SAMP_DIV (`CLK_FREQ_HZ / `SAMP_FREQ_HZ)
`define OSC_FREQ_HZ 307200
`define CONV_OSC_PERIODS 41036
`define CONV_CYCLES ((`CONV_OSC_PERIODS * 64'd25000000) / `OSC_FREQ_HZ)

`endif

/* bus_cond_detect.v */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Start, Stop and clock edge detector for a two-wire bus
// ----------------------------------------------------------------------
module bus_cond_detect
(
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire scl_i,
   input wire sda_i,
   output wire start_o,
   output wire stop_o,
   output wire scl_rise_o,
   output wire scl_fall_o
);

   reg scl_q;
   reg sda_q;

   // Pins are synchronous, so one stage of history is enough for edges.
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_q <= scl_i;
         sda_q <= sda_i;
      end
   end

   // A data edge while the clock stays high marks Start or Stop.
   assign start_o = ce_i & scl_i & scl_q & sda_q & ~sda_i;
   assign stop_o = ce_i & scl_i & scl_q & ~sda_q & sda_i;
   assign scl_rise_o = ce_i & scl_i & ~scl_q;
   assign scl_fall_o = ce_i & ~scl_i & scl_q;
endmodule

/* adc_conv_start_sync.v */
`timescale 1ns/10ps
`include "adc_sync_regs.vh"
// ----------------------------------------------------------------------
// Conversion-start control behind a two-wire target port
// ----------------------------------------------------------------------
module adc_conv_start_sync
#(
   parameter [63:0] CONV_CYCLES = `CONV_CYCLES
)
(
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire scl_i,
   input wire sda_i,
   input wire [6:0] dev_addr_i,
   input wire [23:0] result_i,
   output reg sda_o,
   output reg sda_oe_o,
   output reg [7:0] channel_o,
   output reg converting_o,
   output reg conv_start_o,
   output reg conv_done_o,
   output reg samp_sw_o
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_ACK_A = 3'h2;
   localparam [2:0] ST_WR = 3'h3;
   localparam [2:0] ST_ACK_W = 3'h4;
   localparam [2:0] ST_RD = 3'h5;
   localparam [2:0] ST_ACK_M = 3'h6;
   localparam integer SAMP_DIV_INT = `SAMP_DIV;
   localparam [7:0] SAMP_LAST = SAMP_DIV_INT[7:0] - 8'h01;

   wire start;
   wire stop;
   wire scl_rise;
   wire scl_fall;
   reg [2:0] state;
   reg [3:0] bitcnt;
   reg [7:0] rx;
   reg [7:0] tx;
   reg [1:0] byte_idx;
   reg rw;
   reg wr_sel;
   reg rd_sel;
   reg [7:0] pend_chan;
   reg pend_valid;
   reg [23:0] result;
   reg [63:0] conv_cnt;
   reg [7:0] samp_cnt;
   reg start_conv;
   wire [7:0] next_byte;

   // Returns the result byte selected by index, most significant first.
   function [7:0] result_byte;
      input [23:0] r;
      input [1:0] idx;
      begin
         case (idx)
            2'h0: result_byte = r[23:16];
            2'h1: result_byte = r[15:8];
            default: result_byte = r[7:0];
         endcase
      end
   endfunction

   // True when the address byte should be acknowledged.
   function addr_ack;
      input [7:0] a;
      input [6:0] own;
      input busy;
      begin
         addr_ack = ~busy & ((a[7:1] == own) | ((a[7:1] == `GLOBAL_ADDR) & ~a[0]));
      end
   endfunction

   bus_cond_detect u_cond
   (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .ce_i(ce_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .start_o(start),
      .stop_o(stop),
      .scl_rise_o(scl_rise),
      .scl_fall_o(scl_fall)
   );

   // The byte that follows the one being sent, loaded when the master acknowledges.
   assign next_byte = result_byte(result, byte_idx + 2'h1);

   // ----------------------------------------------------------------------
   // Bus protocol engine
   // ----------------------------------------------------------------------

   // Start aborts anything in flight; Stop restarts conversion only after a selected transfer.
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         rx <= 8'h00;
         tx <= 8'h00;
         byte_idx <= 2'h0;
         rw <= 1'b0;
         wr_sel <= 1'b0;
         rd_sel <= 1'b0;
         pend_chan <= `CHAN_DEFAULT;
         pend_valid <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         start_conv <= 1'b0;
      end
      else if (ce_i)
      begin
         start_conv <= 1'b0;
         // Cleared first so that a byte landing in the same cycle keeps its pending flag.
         if (start_conv)
         begin
            pend_valid <= 1'b0;
         end
         if (stop)
         begin
            // An unacknowledged address never sets a select flag.
            if (wr_sel | rd_sel)
            begin
               start_conv <= 1'b1;
            end
            wr_sel <= 1'b0;
            rd_sel <= 1'b0;
            sda_oe_o <= 1'b0;
            state <= ST_IDLE;
         end
         else if (start)
         begin
            // A repeated Start keeps a pending write selection alive.
            state <= ST_ADDR;
            bitcnt <= 4'h0;
            sda_oe_o <= 1'b0;
         end
         else
         begin
            case (state)
               ST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     rx <= {rx[6:0], sda_i};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && bitcnt == 4'h8)
                  begin
                     rw <= rx[0];
                     bitcnt <= 4'h0;
                     // Busy or global read gets no acknowledge and no data.
                     if (addr_ack(rx, dev_addr_i, converting_o))
                     begin
                        sda_oe_o <= 1'b1;
                        state <= ST_ACK_A;
                     end
                     else
                     begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_A:
               begin
                  if (scl_fall)
                  begin
                     bitcnt <= 4'h0;
                     if (rw)
                     begin
                        rd_sel <= 1'b1;
                        byte_idx <= 2'h0;
                        tx <= {result[22:16], 1'b0};
                        sda_oe_o <= ~result[23];
                        state <= ST_RD;
                     end
                     else
                     begin
                        wr_sel <= 1'b1;
                        sda_oe_o <= 1'b0;
                        state <= ST_WR;
                     end
                  end
               end
               ST_WR:
               begin
                  if (scl_rise)
                  begin
                     rx <= {rx[6:0], sda_i};
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall && bitcnt == 4'h8)
                  begin
                     pend_chan <= rx;
                     pend_valid <= 1'b1;
                     sda_oe_o <= 1'b1;
                     state <= ST_ACK_W;
                  end
               end
               ST_ACK_W:
               begin
                  if (scl_fall)
                  begin
                     bitcnt <= 4'h0;
                     sda_oe_o <= 1'b0;
                     state <= ST_WR;
                  end
               end
               ST_RD:
               begin
                  if (scl_rise)
                  begin
                     bitcnt <= bitcnt + 4'h1;
                  end
                  else if (scl_fall)
                  begin
                     if (bitcnt == 4'h8)
                     begin
                        sda_oe_o <= 1'b0;
                        if (byte_idx == `RESULT_BYTES - 2'h1)
                        begin
                           // Last bit is out: the next conversion need not wait for Stop.
                           start_conv <= 1'b1;
                           rd_sel <= 1'b0;
                           state <= ST_IDLE;
                        end
                        else
                        begin
                           state <= ST_ACK_M;
                        end
                     end
                     else
                     begin
                        sda_oe_o <= ~tx[7];
                        tx <= {tx[6:0], 1'b0};
                     end
                  end
               end
               ST_ACK_M:
               begin
                  if (scl_rise)
                  begin
                     rw <= sda_i; // High means the master declined more data.
                  end
                  else if (scl_fall)
                  begin
                     bitcnt <= 4'h0;
                     if (rw)
                     begin
                        state <= ST_IDLE;
                     end
                     else
                     begin
                        byte_idx <= byte_idx + 2'h1;
                        tx <= {next_byte[6:0], 1'b0};
                        sda_oe_o <= ~next_byte[7];
                        state <= ST_RD;
                     end
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Conversion timing
   // ----------------------------------------------------------------------

   // The converter runs one conversion from reset, then sleeps until a bus event restarts it.
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         converting_o <= 1'b1;
         conv_cnt <= 64'h0;
         samp_cnt <= 8'h00;
         samp_sw_o <= 1'b0;
         channel_o <= `CHAN_DEFAULT;
         result <= 24'h000000;
         conv_start_o <= 1'b0;
         conv_done_o <= 1'b0;
      end
      else if (ce_i)
      begin
         conv_start_o <= start_conv;
         conv_done_o <= 1'b0;
         if (start_conv)
         begin
            // The new channel applies before the first sample is taken.
            if (pend_valid)
            begin
               channel_o <= pend_chan;
            end
            converting_o <= 1'b1;
            conv_cnt <= 64'h0;
            samp_cnt <= 8'h00;
         end
         else if (converting_o)
         begin
            if (conv_cnt == CONV_CYCLES - 64'h1)
            begin
               converting_o <= 1'b0;
               result <= result_i;
               conv_done_o <= 1'b1;
            end
            else
            begin
               conv_cnt <= conv_cnt + 64'h1;
            end
            // One strobe per sampling period; the divider truncates, so the rate runs slightly high.
            if (samp_cnt == SAMP_LAST)
            begin
               samp_cnt <= 8'h00;
               samp_sw_o <= 1'b1;
            end
            else
            begin
               samp_cnt <= samp_cnt + 8'h01;
               samp_sw_o <= 1'b0;
            end
         end
         else
         begin
            samp_sw_o <= 1'b0;
         end
      end
   end
endmodule

/* adc_conv_start_sync_assertions.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Port checker for the conversion-start control
// ----------------------------------------------------------------------
module adc_conv_start_sync_checker
#(
   parameter [63:0] CONV_CYCLES = 64'h7D0
)
(
   input wire clk_i,
   input wire srst_i,
   input wire ce_i,
   input wire scl_i,
   input wire sda_oe_o,
   input wire [7:0] channel_o,
   input wire converting_o,
   input wire conv_start_o,
   input wire conv_done_o,
   input wire samp_sw_o
);
   logic [31:0] cnt;
   logic armed;
   logic [15:0] scnt;
   logic sseen;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i || !ce_i);

   // Cycle counts since the last start and the last sampling pulse; the power-up
   // conversion has no start pulse, so its length is left unmeasured.
   // The counters freeze with the design while the enable is low.
   always @(posedge clk_i)
   begin
      if (srst_i || ce_i)
      begin
         if (srst_i || conv_start_o)
            cnt <= 32'h0;
         else
            cnt <= cnt + 32'h1;
         armed <= !srst_i && (armed || conv_start_o);
         if (srst_i || !converting_o || conv_start_o || samp_sw_o)
            scnt <= 16'h0;
         else
            scnt <= scnt + 16'h1;
         sseen <= !srst_i && converting_o && !conv_start_o && (sseen || samp_sw_o);
      end
   end

   AST_START_BUSY: assert property (conv_start_o |-> converting_o)
      else $error("start pulse without converting");
   AST_START_ONE: assert property (conv_start_o |=> !conv_start_o)
      else $error("start pulse longer than one cycle");
   AST_DONE_IDLE: assert property (conv_done_o |-> ##[0:1] !converting_o)
      else $error("still converting after done");
   AST_CONV_LEN: assert property (conv_done_o && armed |->
      cnt >= CONV_CYCLES - 1 && cnt <= CONV_CYCLES + 1)
      else $error("conversion length wrong");
   AST_SAMP_CONV: assert property (samp_sw_o |-> converting_o)
      else $error("sampling pulse while idle");
   AST_SAMP_PERIOD: assert property (samp_sw_o && sseen |-> scnt == 16'd202)
      else $error("sampling period wrong");
   AST_CHAN_AT_START: assert property ($changed(channel_o) |-> conv_start_o)
      else $error("channel changed without a start");
   AST_NO_ACK_BUSY: assert property ($rose(sda_oe_o) |-> !converting_o)
      else $error("data line pulled while converting");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data line moved while clock high");
endmodule

bind adc_conv_start_sync adc_conv_start_sync_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
   .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
   .channel_o(channel_o),
   .converting_o(converting_o), .conv_start_o(conv_start_o), .conv_done_o(conv_done_o),
   .samp_sw_o(samp_sw_o));

/* i2c_master_model.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Two-wire bus master facing the target port
// ----------------------------------------------------------------------
module i2c_master_model
(
   input wire clk_i,
   input wire sda_i,
   output logic scl_o,
   output logic sda_o
);
   // Both lines rest released, so the pull-up holds them high between frames.
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   // A quarter bit is four clocks, above the three per phase the port needs.
   task automatic quarter();
      repeat (4) @(negedge clk_i);
   endtask

   // Freeing the data line first lets this serve as a repeated Start too.
   task automatic start();
      sda_o = 1'b1;
      quarter();
      scl_o = 1'b1;
      quarter();
      sda_o = 1'b0;
      quarter();
      scl_o = 1'b0;
      quarter();
   endtask

   // Stop is only sent after an acknowledge slot, while the bus is free.
   task automatic stop();
      sda_o = 1'b0;
      quarter();
      scl_o = 1'b1;
      quarter();
      sda_o = 1'b1;
      quarter();
   endtask

   // One clock pulse; the line is sampled in the middle of the high phase.
   task automatic bit_io(input logic b, output logic s);
      sda_o = b;
      quarter();
      scl_o = 1'b1;
      quarter();
      s = sda_i;
      quarter();
      scl_o = 1'b0;
      quarter();
   endtask

   // Eight bits MSB first, then the acknowledge slot; a 1 means listen.
   task automatic xfer(input logic [7:0] w, input logic aw, output logic [7:0] r,
      output logic ar);
      for (int i = 7; i >= 0; i--)
         bit_io(w[i], r[i]);
      bit_io(aw, ar);
   endtask
endmodule

/* adc_conversion_start_sync_bench.sv */
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Self-checking bench for the conversion-start control
// ----------------------------------------------------------------------
module adc_conversion_start_sync_bench;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [6:0] dev = 7'h14;
   logic [23:0] res = 24'h0;
   logic [31:0] seed = 32'h2DCD;
   logic scl, m_sda, sda_o, sda_oe, converting, conv_start, conv_done, samp_sw;
   logic [7:0] channel;
   wire sda = m_sda & ~sda_oe;
   int err_total = 0;
   int num_checks = 0;
   int n_start = 0;
   int n_oe = 0;
   int cycles = 0;

   adc_conv_start_sync #(.CONV_CYCLES(64'h7D0)) u_adc_conv_start_sync (
      .clk_i(clk), .srst_i(srst), .ce_i(ce), .scl_i(scl), .sda_i(sda), .dev_addr_i(dev),
      .result_i(res), .sda_o(sda_o), .sda_oe_o(sda_oe), .channel_o(channel),
      .converting_o(converting), .conv_start_o(conv_start), .conv_done_o(conv_done),
      .samp_sw_o(samp_sw));
   i2c_master_model u_i2c_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));

   always #20 clk = ~clk;

   // Start pulses and pulled cycles are counted; the cycle ceiling cuts a hang short.
   always @(posedge clk)
   begin
      n_start += (conv_start === 1'b1);
      n_oe += (sda_oe === 1'b1);
      cycles++;
      if (cycles == 50000)
      begin
         err_total++;
         report_and_stop();
      end
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Bounded wait for the converter to go to sleep.
   task automatic wait_idle();
      for (int n = 0; n < 2500 && converting !== 1'b0; n++)
         @(negedge clk);
   endtask

   // Start, address, an optional byte once acknowledged, then Stop.
   task automatic frame(input logic [7:0] a, input logic wd, input logic [7:0] d,
      output logic ack);
      logic [7:0] r;
      logic k;
      u_i2c_master_model.start();
      u_i2c_master_model.xfer(a, 1'b1, r, ack);
      if (wd && ack === 1'b0)
         u_i2c_master_model.xfer(d, 1'b1, r, k);
      u_i2c_master_model.stop();
   endtask

   // Main sequence: hand-written corners, then random channel writes, then enable and global-call corners.
   initial
   begin
      logic [7:0] d, b0, b1, b2;
      logic a, k;
      int s;
      res = 24'(rnd());
      repeat (6) @(negedge clk);
      srst = 1'b0;
      chk(channel, 8'h00);
      chk(sda_o, 1'b0);
      frame({dev, 1'b0}, 1'b0, 8'h00, a);
      chk(a, 1'b1);
      chk(n_start, 0);
      $display("busy refusal finished");
      wait_idle();
      s = n_start;
      u_i2c_master_model.start();
      u_i2c_master_model.xfer({dev, 1'b1}, 1'b1, d, a);
      u_i2c_master_model.xfer(8'hFF, 1'b0, b0, k);
      u_i2c_master_model.xfer(8'hFF, 1'b0, b1, k);
      u_i2c_master_model.xfer(8'hFF, 1'b1, b2, k);
      chk(a, 1'b0);
      chk({b0, b1, b2}, res);
      chk(n_start, s + 1);
      u_i2c_master_model.stop();
      wait_idle();
      s = n_start;
      u_i2c_master_model.start();
      u_i2c_master_model.xfer({dev, 1'b1}, 1'b1, d, a);
      u_i2c_master_model.xfer(8'hFF, 1'b1, b0, k);
      u_i2c_master_model.stop();
      chk(b0, res[23:16]);
      chk(n_start, s + 1);
      $display("read tests finished");
      for (int i = 0; i < 4; i++)
      begin
         dev = 7'(rnd());
         if (dev[6:1] == 6'h3B)
            dev = 7'h14;
         d = 8'(rnd());
         wait_idle();
         s = n_start;
         frame({dev ^ 7'h01, 1'b0}, 1'b1, d, a);
         chk(a, 1'b1);
         frame({dev, 1'b0}, 1'b1, d, a);
         chk(a, 1'b0);
         chk(n_start, s + 1);
         chk(channel, d);
      end
      wait_idle();
      s = n_start;
      frame({dev, 1'b0}, 1'b0, 8'h00, a);
      chk(n_start, s + 1);
      chk(channel, d);
      // A frozen enable must stop the conversion from running out.
      ce = 1'b0;
      repeat (2500) @(negedge clk);
      ce = 1'b1;
      chk(converting, 1'b1);
      chk(conv_done, 1'b0);
      $display("own writes finished");
      wait_idle();
      d = 8'(rnd());
      frame(8'hEE, 1'b1, d, a);
      chk(a, 1'b0);
      chk(channel, d);
      frame(8'hEE, 1'b0, 8'h00, a);
      chk(a, 1'b1);
      wait_idle();
      s = n_start;
      frame(8'hEE, 1'b0, 8'h00, a);
      chk(n_start, s + 1);
      chk(channel, d);
      wait_idle();
      s = n_oe;
      frame(8'hEF, 1'b0, 8'h00, a);
      chk(a, 1'b1);
      chk(n_oe, s);
      chk(converting, 1'b0);
      $display("global calls finished");
      report_and_stop();
   end
endmodule
